// ===== include/sef_pkg.sv
package sef_pkg;

    // serial framing
    localparam int          BYTE_BITS = 8;
    localparam logic [2:0]  BIT_FIRST = 3'h0;
    localparam logic [2:0]  BIT_LAST  = 3'h7;
    localparam logic [7:0]  BYTE_ZERO = 8'h00;

    // internal write cycle time, longest, rounded down to clock cycles
    localparam int          CLK_HZ        = 40_000_000;
    localparam int          WRITE_TIME_MS = 5;
    localparam int          WRITE_CYCLES  = WRITE_TIME_MS * (CLK_HZ / 1000);
    localparam int          TMR_W         = $clog2(WRITE_CYCLES + 1);

    // frame state: unarmed after reset, idle, selected
    typedef enum logic [1:0] {
        FR_OFF  = 2'b00,
        FR_IDLE = 2'b01,
        FR_SEL  = 2'b10
    } sef_state_type;

    // synchroniser state
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } sef_sync_type;

    // framing block state
    typedef struct packed {
        sef_state_type    frame;
        logic [2:0]       bit_cnt;
        logic             got_byte;
        logic [7:0]       rx_sh;
        logic [7:0]       tx_sh;
        logic [7:0]       rx_byte;
        logic             rx_valid;
        logic             so;
        logic             so_oe_n;
        logic             busy;
        logic [TMR_W-1:0] timer;
        logic             write_start;
        logic             write_abort;
        logic             standby;
        logic             selected;
    } sef_regs_type;

    localparam sef_regs_type REGS_RST = '{
        frame:    FR_OFF,
        so_oe_n:  1'b1,
        standby:  1'b1,
        default:  '0
    };

endpackage : sef_pkg

// ===== include/sef_edge_if.sv
`timescale 1ns/10ps
// synchronised pin level with its edges
interface sef_edge_if;
    logic level;
    logic rise;
    logic fall;

    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface : sef_edge_if

// ===== design/sef_pin_sync.sv
`timescale 1ns/10ps
module sef_pin_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input  wire logic   clock_in,
    input  wire logic   sys_rst_in,
    // raw pin
    input  wire logic   pin_in,
    // synchronised level and edges
    sef_edge_if.src     pin_if
);

    sef_pkg::sef_sync_type q;
    sef_pkg::sef_sync_type d;

    // two flops, then a third copy for edge finding
    always_comb
    begin
        d.meta = pin_in;
        d.sync = q.meta;
        d.last = q.sync;
    end

    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            q <= '{meta: RST_VAL, sync: RST_VAL, last: RST_VAL};
        end
        else
        begin
            q <= d;
        end
    end

    // only the second flop and its copy are looked at
    assign pin_if.level = q.sync;
    assign pin_if.rise  = q.sync & ~q.last;
    assign pin_if.fall  = ~q.sync & q.last;

endmodule : sef_pin_sync

// ===== design/sef_frame_top.sv
// How it works
// - low select means selected, traffic only then
// - select high deselects, standby unless programming
// - started programming cycle always runs to end
// - standby right after programming ends if deselected
// - output goes high impedance on deselect
// - select rise after valid write starts cycle
// - ignore traffic until first select falling edge
// - serial input captured on clock rising edge
// - instruction, address, data share one input
// - internal write finishes within 5 ms
// - output changes after clock falling edge
// - bytes shifted most significant bit first
// - select rise off byte boundary abandons write
`timescale 1ns/10ps
module sef_frame_top #(
    parameter int WRITE_CYCLES = sef_pkg::WRITE_CYCLES
) (
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        sys_rst_in,
    // serial pins from the master
    input  wire logic        spi_cs_n_in,
    input  wire logic        spi_sck_in,
    input  wire logic        spi_si_in,
    // serial output pin, enable low while driving
    output logic             spi_so_out,
    output logic             spi_so_oe_n_out,
    // byte stream toward the command logic
    output logic [7:0]       rx_byte_out,
    output logic             rx_valid_out,
    input  wire logic [7:0]  tx_byte_in,
    // write sequence handshake with the command logic
    input  wire logic        wr_seq_ok_in,
    output logic             write_start_out,
    output logic             write_abort_out,
    // device status
    output logic             selected_out,
    output logic             standby_out,
    output logic             write_busy_out
);

    localparam logic [sef_pkg::TMR_W-1:0] TMR_LAST =
        sef_pkg::TMR_W'(WRITE_CYCLES - 1);
    localparam logic [sef_pkg::TMR_W-1:0] TMR_ZERO = '0;

    sef_edge_if cs_if ();
    sef_edge_if sck_if ();
    sef_edge_if si_if ();

    sef_pkg::sef_regs_type q;
    sef_pkg::sef_regs_type d;

    logic sel_now;
    logic end_on_byte;

    // pin synchronisers; select resets low so a select held low
    // through reset is no falling edge and cannot arm the frame
    sef_pin_sync #(.RST_VAL(1'b0)) u_cs_sync (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .pin_in     (spi_cs_n_in),
        .pin_if     (cs_if)
    );

    // serial clock idles high between frames, so no false edge
    sef_pin_sync #(.RST_VAL(1'b1)) u_sck_sync (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .pin_in     (spi_sck_in),
        .pin_if     (sck_if)
    );

    sef_pin_sync #(.RST_VAL(1'b0)) u_si_sync (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .pin_in     (spi_si_in),
        .pin_if     (si_if)
    );

    // frame ended cleanly after a whole number of bytes
    assign sel_now     = (q.frame == sef_pkg::FR_SEL);
    assign end_on_byte = q.got_byte && (q.bit_cnt == sef_pkg::BIT_FIRST);

    // next state of the whole block
    always_comb
    begin
        d             = q;
        d.rx_valid    = 1'b0;
        d.write_start = 1'b0;
        d.write_abort = 1'b0;

        // self-timed write runs regardless of select
        if (q.busy)
        begin
            if (q.timer == TMR_LAST)
            begin
                d.busy  = 1'b0;
                d.timer = TMR_ZERO;
            end
            else
            begin
                d.timer = q.timer + 1'b1;
            end
        end

        case (q.frame)
            sef_pkg::FR_OFF,
            sef_pkg::FR_IDLE:
            begin
                // first falling edge arms and selects
                if (cs_if.fall)
                begin
                    d.frame    = sef_pkg::FR_SEL;
                    d.bit_cnt  = sef_pkg::BIT_FIRST;
                    d.got_byte = 1'b0;
                end
            end
            sef_pkg::FR_SEL:
            begin
                if (cs_if.rise)
                begin
                    d.frame = sef_pkg::FR_IDLE;
                    if (end_on_byte && wr_seq_ok_in && !q.busy)
                    begin
                        d.write_start = 1'b1;
                        d.busy        = 1'b1;
                        d.timer       = TMR_ZERO;
                    end
                    else if (wr_seq_ok_in)
                    begin
                        d.write_abort = 1'b1;
                    end
                end
                else
                begin
                    // capture on rising clock, msb first
                    if (sck_if.rise)
                    begin
                        d.rx_sh   = {q.rx_sh[6:0], si_if.level};
                        d.bit_cnt = q.bit_cnt + 1'b1;
                        if (q.bit_cnt == sef_pkg::BIT_LAST)
                        begin
                            d.rx_byte  = {q.rx_sh[6:0], si_if.level};
                            d.rx_valid = 1'b1;
                            d.got_byte = 1'b1;
                        end
                    end
                    // drive out after falling clock, msb first
                    if (sck_if.fall)
                    begin
                        if (q.bit_cnt == sef_pkg::BIT_FIRST)
                        begin
                            d.so    = tx_byte_in[7];
                            d.tx_sh = {tx_byte_in[6:0], 1'b0};
                        end
                        else
                        begin
                            d.so    = q.tx_sh[7];
                            d.tx_sh = {q.tx_sh[6:0], 1'b0};
                        end
                    end
                end
            end
            default:
            begin
                d.frame = sef_pkg::FR_OFF;
            end
        endcase

        // output released as soon as the frame ends
        d.so_oe_n  = (d.frame != sef_pkg::FR_SEL);
        d.selected = (d.frame == sef_pkg::FR_SEL);
        // standby only when not selected and not programming
        d.standby  = (d.frame != sef_pkg::FR_SEL) && !d.busy;
    end

    // single state register
    always_ff @(posedge clock_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            q <= sef_pkg::REGS_RST;
        end
        else
        begin
            q <= d;
        end
    end

    // outputs straight from flops
    assign spi_so_out      = q.so;
    assign spi_so_oe_n_out = q.so_oe_n;
    assign rx_byte_out     = q.rx_byte;
    assign rx_valid_out    = q.rx_valid;
    assign write_start_out = q.write_start;
    assign write_abort_out = q.write_abort;
    assign selected_out    = q.selected;
    assign standby_out     = q.standby;
    assign write_busy_out  = q.busy;

    // checks
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (sys_rst_in);

    sequence s_clean_end;
        sel_now && cs_if.rise && end_on_byte && wr_seq_ok_in && !q.busy;
    endsequence

    sequence s_write_begun;
        q.write_start && q.busy && (q.timer == TMR_ZERO);
    endsequence

    a_unarmed_no_rx: assert property (
        (q.frame == sef_pkg::FR_OFF && !cs_if.fall)
        |=> !q.rx_valid && !q.selected)
        else $error("traffic taken before first select");

    a_select_on_fall: assert property (
        (!sel_now && cs_if.fall) |=> q.selected && !q.standby)
        else $error("select fall did not select");

    a_deselect_rise: assert property (
        (sel_now && cs_if.rise && !q.busy && !wr_seq_ok_in)
        |=> !q.selected && q.standby)
        else $error("select rise did not reach standby");

    a_so_released: assert property (
        (sel_now && cs_if.rise) |=> spi_so_oe_n_out)
        else $error("output still driven after deselect");

    a_write_starts: assert property (
        s_clean_end |=> s_write_begun ##1 (q.busy && !q.write_start))
        else $error("write cycle did not start");

    a_prog_runs: assert property (
        (q.busy && q.timer != TMR_LAST) |=> q.busy)
        else $error("programming cycle cut short");

    a_write_bounded: assert property (
        $fell(q.busy) |-> $past(q.timer) == TMR_LAST)
        else $error("write cycle length wrong");

    a_standby_after: assert property (
        ($fell(q.busy) && !q.selected) |-> q.standby)
        else $error("no standby after programming");

    a_rx_capture: assert property (
        (sel_now && !cs_if.rise && sck_if.rise
         && q.bit_cnt == sef_pkg::BIT_LAST)
        |=> q.rx_valid && q.rx_byte == {$past(q.rx_sh[6:0]),
                                        $past(si_if.level)})
        else $error("received byte wrong");

    a_so_on_fall: assert property (
        (sel_now && !cs_if.rise && sck_if.fall
         && q.bit_cnt == sef_pkg::BIT_FIRST)
        |=> spi_so_out == $past(tx_byte_in[7]))
        else $error("output bit not updated after fall");

    a_abort_write: assert property (
        (sel_now && cs_if.rise && wr_seq_ok_in && !end_on_byte)
        |=> q.write_abort && !q.write_start)
        else $error("misaligned deselect did not abandon write");

endmodule : sef_frame_top

// ===== verification/sef_spi_master.sv
`timescale 1ns/10ps
// serial master model, clock idle high and still between frames
module sef_spi_master (
    // clock
    input  wire logic clock_in,
    // serial pins
    input  wire logic so_in,
    output logic      cs_n_out,
    output logic      sck_out,
    output logic      si_out
);
    // idle levels at time zero
    initial
    begin
        cs_n_out = 1'b1;
        sck_out  = 1'b1;
        si_out   = 1'b0;
    end

    // select level change, then setup or hold gap
    task cs_set(input logic lvl);
        cs_n_out <= lvl;
        if (lvl)
            si_out <= ~si_out; // released line shows no stale bit
        repeat (4) @(posedge clock_in);
    endtask : cs_set

    // shift bits out msb first, sample output at each rise
    task xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < nbits; i++)
        begin
            sck_out <= 1'b0;
            si_out  <= tx[7 - i];
            repeat (4) @(posedge clock_in);
            sck_out <= 1'b1;
            rx = {rx[6:0], so_in};
            repeat (4) @(posedge clock_in);
        end
    endtask : xfer
endmodule : sef_spi_master

// ===== verification/tb.sv
`timescale 1ns/10ps
module tb;
    // clock, reset, pins and user side
    localparam int WR_CYC = 20;
    logic       clock_in;
    logic       sys_rst_in;
    logic       cs_n, sck, si, so, so_oe_n;
    logic       so_last;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    logic       wr_ok;
    logic       rx_valid, wr_start, wr_abort, selected, standby, busy;
    wire logic  so_line;
    logic [7:0] got;
    int         miscompares  = 0;
    int         total_checks = 0;
    int         n_rx, n_start, n_abort, n_busy;

    // levels at time zero
    initial
    begin
        clock_in   = 1'b0;
        sys_rst_in = 1'b1;
        so_last    = 1'b0;
        tx_byte    = 8'h3C;
        wr_ok      = 1'b0;
    end

    always #12.5 clock_in = ~clock_in;

    // released output shows the inverse of its last level
    assign so_line = so_oe_n ? ~so_last : so;

    // pulse and busy counters, sampled on the falling clock so that
    // they never race the checks made at the rising edge
    always @(negedge clock_in)
    begin
        if (so_oe_n === 1'b0) so_last <= so;
        if (rx_valid === 1'b1) n_rx++;
        if (wr_start === 1'b1) n_start++;
        if (wr_abort === 1'b1) n_abort++;
        if (busy === 1'b1) n_busy++;
    end

    sef_frame_top #(.WRITE_CYCLES(WR_CYC)) u_sef_frame_top (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .spi_cs_n_in(cs_n), .spi_sck_in(sck), .spi_si_in(si),
        .spi_so_out(so), .spi_so_oe_n_out(so_oe_n),
        .rx_byte_out(rx_byte), .rx_valid_out(rx_valid),
        .tx_byte_in(tx_byte), .wr_seq_ok_in(wr_ok),
        .write_start_out(wr_start), .write_abort_out(wr_abort),
        .selected_out(selected), .standby_out(standby),
        .write_busy_out(busy)
    );

    sef_spi_master u_sef_spi_master (
        .clock_in(clock_in), .so_in(so_line),
        .cs_n_out(cs_n), .sck_out(sck), .si_out(si)
    );

    // one comparison
    task check(input string name, input logic [7:0] exp,
               input logic [7:0] seen);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // clear counters
    task zero();
        n_rx = 0;
        n_start = 0;
        n_abort = 0;
        n_busy = 0;
    endtask : zero

    // traffic before the first select is ignored
    task t_unarmed();
        zero();
        u_sef_spi_master.xfer(8'hFF, 8, got);
        check("rx_count", 8'h00, 8'(n_rx));
        check("selected", 8'h00, {7'h00, selected});
        check("standby", 8'h01, {7'h00, standby});
        check("so_oe_n", 8'h01, {7'h00, so_oe_n});
    endtask : t_unarmed

    // two bytes each way, then plain deselect
    task t_read();
        zero();
        u_sef_spi_master.cs_set(1'b0);
        check("selected", 8'h01, {7'h00, selected});
        check("standby", 8'h00, {7'h00, standby});
        check("so_oe_n", 8'h00, {7'h00, so_oe_n});
        u_sef_spi_master.xfer(8'hA5, 8, got);
        check("rx_byte", 8'hA5, rx_byte);
        check("so_byte", 8'h3C, got);
        tx_byte <= 8'hC3;
        u_sef_spi_master.xfer(8'h5A, 8, got);
        check("rx_byte", 8'h5A, rx_byte);
        check("so_byte", 8'hC3, got);
        check("rx_count", 8'h02, 8'(n_rx));
        u_sef_spi_master.cs_set(1'b1);
        check("so_oe_n", 8'h01, {7'h00, so_oe_n});
        check("standby", 8'h01, {7'h00, standby});
        check("starts", 8'h00, 8'(n_start + n_abort));
    endtask : t_read

    // write start, select during busy, standby after
    task t_write();
        zero();
        wr_ok <= 1'b1;
        u_sef_spi_master.cs_set(1'b0);
        u_sef_spi_master.xfer(8'h02, 8, got);
        u_sef_spi_master.xfer(8'hAB, 8, got);
        u_sef_spi_master.cs_set(1'b1);
        check("starts", 8'h01, 8'(n_start));
        check("busy", 8'h01, {7'h00, busy});
        check("standby", 8'h00, {7'h00, standby});
        wr_ok <= 1'b0;
        u_sef_spi_master.cs_set(1'b0);
        check("selected", 8'h01, {7'h00, selected});
        u_sef_spi_master.cs_set(1'b1);
        check("busy", 8'h01, {7'h00, busy});
        check("standby", 8'h00, {7'h00, standby});
        for (int i = 0; i < 40 && busy === 1'b1; i++)
            @(posedge clock_in);
        @(posedge clock_in);
        check("busy_cycles", 8'(WR_CYC), 8'(n_busy));
        check("standby", 8'h01, {7'h00, standby});
        check("starts", 8'h01, 8'(n_start));
    endtask : t_write

    // deselect off a byte boundary abandons the write
    task t_abort();
        zero();
        wr_ok <= 1'b1;
        u_sef_spi_master.cs_set(1'b0);
        u_sef_spi_master.xfer(8'h06, 8, got);
        u_sef_spi_master.xfer(8'h55, 3, got);
        u_sef_spi_master.cs_set(1'b1);
        check("aborts", 8'h01, 8'(n_abort));
        check("starts", 8'h00, 8'(n_start));
        check("busy", 8'h00, {7'h00, busy});
        check("rx_count", 8'h01, 8'(n_rx));
        wr_ok <= 1'b0;
    endtask : t_abort

    // reset in mid-frame with select held low: unarmed until a new fall
    task t_rearm();
        zero();
        u_sef_spi_master.cs_set(1'b0);
        check("selected", 8'h01, {7'h00, selected});
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        u_sef_spi_master.xfer(8'hFF, 8, got);
        check("rx_count", 8'h00, 8'(n_rx));
        check("selected", 8'h00, {7'h00, selected});
        check("so_oe_n", 8'h01, {7'h00, so_oe_n});
        u_sef_spi_master.cs_set(1'b1);
        u_sef_spi_master.cs_set(1'b0);
        check("selected", 8'h01, {7'h00, selected});
        u_sef_spi_master.cs_set(1'b1);
        check("standby", 8'h01, {7'h00, standby});
    endtask : t_rearm

    // verdict and end of run
    task tally_and_finish();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    // main sequence
    initial
    begin
        repeat (16) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        t_unarmed();
        t_read();
        t_write();
        t_abort();
        t_rearm();
        tally_and_finish();
    end

    // watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge clock_in);
        miscompares++;
        $display("Error watchdog expected done seen hang");
        tally_and_finish();
    end
endmodule : tb
